/* File: hw/lcd_cmd_pkg.sv */
/*
   Shared constants, encodings and carriers for the display RAM command decoder.
   Assumes a single 125 MHz clock domain and a byte-wide host port sampled on it.
*/
package lcd_cmd_pkg;
   localparam int COL_W      = 8;
   localparam int PAGE_W     = 4;
   localparam int LINE_W     = 7;
   localparam int COLUMNS    = 160;
   localparam int FIFO_DEPTH = 16;
   localparam int INIT_CYCLES = 16;

   localparam logic [3:0] OP_PAGE     = 4'hb;
   localparam logic [3:0] OP_COL_HI   = 4'h1;
   localparam logic [3:0] OP_COL_LO   = 4'h0;
   localparam logic [7:0] OP_HOLD_SET = 8'he0;
   localparam logic [7:0] OP_HOLD_CLR = 8'hee;
   localparam logic [6:0] OP_DISP     = 7'h57;
   localparam logic [5:0] OP_LINE     = 6'h10;
   localparam logic [5:0] OP_ROW      = 6'h11;

   localparam logic [PAGE_W-1:0] RST_PAGE = 4'h0;
   localparam logic [COL_W-1:0]  RST_COL  = 8'h00;
   localparam logic [LINE_W-1:0] RST_LINE = 7'h00;
   localparam logic [LINE_W-1:0] RST_ROW  = 7'h00;

   typedef struct packed {
      logic       busy;
      logic       disp_on;
      logic       reset_progress_flag;
      logic [2:0] maker_identity_field;
      logic [1:0] panel_size_field;
   } status_s;

   typedef struct packed {
      logic [PAGE_W-1:0] page;
      logic [COL_W-1:0]  column;
   } ram_addr_s;

   typedef struct packed {
      ram_addr_s  addr;
      logic [7:0] data;
   } ram_wr_s;

   typedef enum logic [1:0] {
      IDLE,
      WANT_LINE,
      WANT_ROW
   } seq_e;
endpackage

/* File: hw/byte_fifo.sv */
/*
   Parameterised synchronous FIFO with valid/ready on both sides.
   Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module byte_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   input  wire logic             i_clk,
   input  wire logic             i_sys_rst,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic [WIDTH-1:0]      o_out_data
);
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH)
      begin : g_bad_depth
         $error("FIFO depth must be a power of two of at least two");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign o_in_ready  = (count != (AW+1)'(DEPTH));
   assign o_out_valid = (count != '0);
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;
   assign o_out_data  = mem[rd_ptr];

   always_ff @(posedge i_clk)
   begin
      if (push)
         mem[wr_ptr] <= i_in_data;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + AW'(1);
         if (pop)
            rd_ptr <= rd_ptr + AW'(1);
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // byte_fifo

/* File: hw/display_ram_command_decoder.sv */
/*
   Instruction decoder for a grayscale graphic LCD controller: host byte port,
   status byte, page/column pointers, read-hold mode, display enable and
   start-line / start-row scroll registers. Display data writes leave through a
   16-word FIFO to an external display RAM; reads use a one-cycle RAM port.
   Assumes host strobes are synchronous to i_clk, one access per strobe.
*/
`timescale 1ns/1ps
module display_ram_command_decoder
   import lcd_cmd_pkg::*;
#(
   parameter int COLUMN_COUNT = COLUMNS,
   parameter int INIT_COUNT   = INIT_CYCLES,
   parameter int WR_DEPTH     = FIFO_DEPTH
)
(
   input  wire logic              i_clk,
   input  wire logic              i_sys_rst,
   input  wire logic              i_chip_select_low,
   input  wire logic              i_data_command_select,
   input  wire logic              i_read_not_write,
   input  wire logic              i_strobe,
   input  wire logic [7:0]        i_wdata,
   output logic [7:0]             o_rdata,
   output logic                   o_busy,
   input  wire logic [2:0]        i_maker_identity_field,
   input  wire logic [1:0]        i_panel_size_field,
   output ram_wr_s                o_ram_wr,
   output logic                   o_ram_wr_valid,
   input  wire logic              i_ram_wr_ready,
   output logic                   o_ram_rd_en,
   output ram_addr_s              o_ram_rd_addr,
   input  wire logic [7:0]        i_ram_rdata,
   output logic                   o_panel_enable,
   output logic [LINE_W-1:0]      o_start_line,
   output logic [LINE_W-1:0]      o_start_row,
   output logic [PAGE_W-1:0]      o_page,
   output logic [COL_W-1:0]       o_column,
   output logic                   o_read_hold
);
   localparam logic [COL_W-1:0] LAST_COL = COL_W'(COLUMN_COUNT - 1);
   localparam int               CNT_W    = $clog2(INIT_COUNT + 1);

   generate
      if (COLUMN_COUNT < 2 || COLUMN_COUNT > (1 << COL_W) || INIT_COUNT < 1)
      begin : g_bad_param
         $error("Column count or init count out of range");
      end
   endgenerate

   logic [CNT_W-1:0]  init_cnt;
   logic              reset_progress_flag;
   logic              fifo_in_ready;
   logic              fifo_out_valid;
   logic              cmd_ok;
   logic              data_wr;
   logic              data_rd;
   logic              stat_rd;
   logic              host_access;
   logic [COL_W-1:0]  next_column;
   logic [COL_W-1:0]  saved_column;
   logic [7:0]        read_buf;
   logic              rd_pend;
   seq_e              seq;
   status_s           status;
   ram_wr_s           wr_word;

   // Post-reset initialisation: busy and reset flag stand until the count ends
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         init_cnt <= CNT_W'(INIT_COUNT);
      else if (init_cnt != '0)
         init_cnt <= init_cnt - CNT_W'(1);
   end

   assign reset_progress_flag = (init_cnt != '0);
   // A full write FIFO or the post-reset initialisation holds the host off
   assign o_busy = reset_progress_flag || !fifo_in_ready;

   assign host_access = i_strobe && !i_chip_select_low;
   // Status is always readable, so the host can poll busy
   assign stat_rd = host_access && !i_data_command_select && i_read_not_write;
   // Every other access is dropped while busy
   assign cmd_ok  = host_access && !o_busy && !i_data_command_select
                    && !i_read_not_write;
   assign data_wr = host_access && !o_busy && i_data_command_select
                    && !i_read_not_write;
   // Reads are dropped while queued writes remain, so they never return stale RAM
   assign data_rd = host_access && !o_busy && i_data_command_select
                    && i_read_not_write && !fifo_out_valid;

   assign status.busy                 = o_busy;
   assign status.disp_on              = o_panel_enable;
   assign status.reset_progress_flag  = reset_progress_flag;
   assign status.maker_identity_field = i_maker_identity_field;
   assign status.panel_size_field     = i_panel_size_field;

   always_comb
   begin
      if (o_column == LAST_COL)
         next_column = '0;
      else
         next_column = o_column + COL_W'(1);
   end

   // Column pointer: loads, auto-advance and hold restore
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_column <= RST_COL;
      else if (data_wr)
         o_column <= next_column;
      else if (data_rd && !o_read_hold)
         o_column <= next_column;
      else if (cmd_ok && seq == IDLE && i_wdata[7:4] == OP_COL_HI)
         o_column <= {i_wdata[3:0], o_column[3:0]};
      else if (cmd_ok && seq == IDLE && i_wdata[7:4] == OP_COL_LO)
         o_column <= {o_column[7:4], i_wdata[3:0]};
      else if (cmd_ok && seq == IDLE && i_wdata == OP_HOLD_CLR && o_read_hold)
         o_column <= saved_column;
   end

   // Read-hold mode and the column it returns to
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_read_hold  <= 1'b0;
         saved_column <= RST_COL;
      end
      else if (cmd_ok && seq == IDLE && i_wdata == OP_HOLD_SET)
      begin
         o_read_hold  <= 1'b1;
         saved_column <= o_column;
      end
      else if (cmd_ok && seq == IDLE && i_wdata == OP_HOLD_CLR)
         o_read_hold <= 1'b0;
   end

   // Page pointer has only four bits, so page sixteen is out of reach here
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_page <= RST_PAGE;
      else if (cmd_ok && seq == IDLE && i_wdata[7:4] == OP_PAGE)
         o_page <= i_wdata[3:0];
   end

   // Display enable gates the panel; scroll and pointer outputs still update while it is low
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_panel_enable <= 1'b0;
      else if (cmd_ok && seq == IDLE && i_wdata[7:1] == OP_DISP)
         o_panel_enable <= i_wdata[0];
   end

   // Two-byte sequencer: first byte arms, next command byte carries the value
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         seq <= IDLE;
      else if (cmd_ok)
      begin
         unique case (seq)
            IDLE:
            begin
               if (i_wdata[7:2] == OP_LINE)
                  seq <= WANT_LINE;
               else if (i_wdata[7:2] == OP_ROW)
                  seq <= WANT_ROW;
            end
            WANT_LINE:
               seq <= IDLE;
            WANT_ROW:
               seq <= IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_start_line <= RST_LINE;
         o_start_row  <= RST_ROW;
      end
      else if (cmd_ok && seq == WANT_LINE)
         o_start_line <= i_wdata[6:0];
      else if (cmd_ok && seq == WANT_ROW)
         o_start_row <= i_wdata[6:0];
   end

   // Read pipeline: each read returns the fetch of the last read made two or more cycles before it, hence the dummy read
   assign o_ram_rd_en        = data_rd;
   assign o_ram_rd_addr.page   = o_page;
   assign o_ram_rd_addr.column = o_column;

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         rd_pend <= 1'b0;
      else
         rd_pend <= data_rd;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         read_buf <= 8'h00;
      else if (rd_pend)
         read_buf <= i_ram_rdata;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_rdata <= 8'h00;
      else if (stat_rd)
         o_rdata <= status;
      else if (data_rd)
         o_rdata <= read_buf;
   end

   assign wr_word.addr.page   = o_page;
   assign wr_word.addr.column = o_column;
   assign wr_word.data        = i_wdata;

   byte_fifo
   #(
      .WIDTH ($bits(ram_wr_s)),
      .DEPTH (WR_DEPTH)
   )
   u_wr_fifo
   (
      .i_clk       (i_clk),
      .i_sys_rst   (i_sys_rst),
      .i_in_valid  (data_wr),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (wr_word),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (i_ram_wr_ready),
      .o_out_data  (o_ram_wr)
   );

   assign o_ram_wr_valid = fifo_out_valid;

   sequence s_line_first;
      cmd_ok && seq == IDLE && i_wdata[7:2] == OP_LINE;
   endsequence

   sequence s_row_first;
      cmd_ok && seq == IDLE && i_wdata[7:2] == OP_ROW;
   endsequence

   sequence s_hold_enter;
      cmd_ok && seq == IDLE && i_wdata == OP_HOLD_SET;
   endsequence

   sequence s_hold_cancel;
      cmd_ok && seq == IDLE && i_wdata == OP_HOLD_CLR;
   endsequence

   a_col_advance: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      data_wr && o_column != LAST_COL |=> o_column == $past(o_column) + COL_W'(1))
      else $error("column did not advance after a data write");

   a_col_wrap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      data_wr && o_column == LAST_COL |=> o_column == '0)
      else $error("column did not wrap to zero");

   a_status_byte: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      stat_rd |=> o_rdata == {$past(o_busy), $past(o_panel_enable),
                  $past(reset_progress_flag), $past(i_maker_identity_field),
                  $past(i_panel_size_field)})
      else $error("status byte layout wrong");

   a_busy_reject: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      host_access && o_busy |=> $stable(o_page) && $stable(o_column)
      && $stable(o_panel_enable) && $stable(o_read_hold) && $stable(seq))
      else $error("instruction acted while busy");

   a_init_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $fell(i_sys_rst) |-> reset_progress_flag && o_busy)
      else $error("reset flag or busy not raised after reset");

   a_page_load: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      cmd_ok && seq == IDLE && i_wdata[7:4] == OP_PAGE
      |=> o_page == $past(i_wdata[3:0]) && $stable(o_column))
      else $error("page pointer not loaded");

   a_col_upper: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      cmd_ok && seq == IDLE && i_wdata[7:4] == OP_COL_HI
      |=> o_column[7:4] == $past(i_wdata[3:0]) && $stable(o_column[3:0]))
      else $error("column upper bits not loaded");

   a_col_lower: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      cmd_ok && seq == IDLE && i_wdata[7:4] == OP_COL_LO
      |=> o_column[3:0] == $past(i_wdata[3:0]) && $stable(o_column[7:4]))
      else $error("column lower bits not loaded");

   a_hold_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      data_rd && o_read_hold |=> $stable(o_column))
      else $error("column moved on a held read");

   a_hold_restore: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      s_hold_enter ##1 !host_access ##1 data_wr ##1 s_hold_cancel
      |=> !o_read_hold && o_column == $past(o_column, 4))
      else $error("hold cancel did not restore column");

   a_disp_ctl: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      cmd_ok && seq == IDLE && i_wdata[7:1] == OP_DISP
      |=> o_panel_enable == $past(i_wdata[0]) && $stable(o_page) && $stable(o_column))
      else $error("display enable not applied");

   a_start_line: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      s_line_first ##1 cmd_ok |=> o_start_line == $past(i_wdata[6:0]))
      else $error("start line not loaded from second byte");

   a_start_row: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      s_row_first ##1 cmd_ok |=> o_start_row == $past(i_wdata[6:0])
      && $stable(o_start_line))
      else $error("start row not loaded from second byte");

   a_read_advance: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      data_rd && !o_read_hold && o_column != LAST_COL
      |=> o_column == $past(o_column) + COL_W'(1))
      else $error("column did not advance after a data read");

   a_wr_capture: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      data_wr && !fifo_out_valid
      |=> o_ram_wr_valid && o_ram_wr == {$past(o_page), $past(o_column), $past(i_wdata)})
      else $error("write word not queued at page and column");

   a_rdata_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !stat_rd && !data_rd |=> $stable(o_rdata))
      else $error("read byte changed without a read");

   a_scroll_keep: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !cmd_ok |=> $stable(o_start_line) && $stable(o_start_row) && $stable(o_panel_enable))
      else $error("scroll or enable changed without an accepted command");

   a_page_only: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      cmd_ok && seq == IDLE && i_wdata[7:4] == OP_PAGE
      |=> $stable(o_start_line) && $stable(o_start_row) && $stable(o_panel_enable))
      else $error("page change disturbed the shown image");
endmodule // display_ram_command_decoder

/* File: tb/ram_model.sv */
/*
   Behavioural display RAM on the far side of the decoder's RAM ports.
   Assumes the write port is valid/ready and the read data is wanted the cycle after rd_en.
*/
`timescale 1ns/1ps
module ram_model
   import lcd_cmd_pkg::*;
(
   input  wire logic      i_clk,
   input  wire logic      i_sys_rst,
   input  wire logic      i_stall,
   input  wire logic      i_slow,
   input  wire ram_wr_s   i_wr,
   input  wire logic      i_wr_valid,
   output logic           o_wr_ready,
   input  wire logic      i_rd_en,
   input  wire ram_addr_s i_rd_addr,
   output logic [7:0]     o_rdata
);
   logic [7:0] mem [0:16*COLUMNS-1];
   logic       phase;

   // Slow mode accepts only every other cycle
   assign o_wr_ready = !i_stall && (!i_slow || phase);

   always_ff @(posedge i_clk)
   begin
      phase <= i_sys_rst ? 1'b0 : !phase;
      if (i_wr_valid && o_wr_ready)
         mem[int'(i_wr.addr.page) * COLUMNS + int'(i_wr.addr.column)] <= i_wr.data;
   end

   // Data is valid for one cycle only; afterwards it flips so a late sample is seen
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_rdata <= 8'h00;
      else if (i_rd_en)
         o_rdata <= mem[int'(i_rd_addr.page) * COLUMNS + int'(i_rd_addr.column)];
      else
         o_rdata <= ~o_rdata;
   end
endmodule // ram_model

/* File: tb/test_display_ram_command_decoder.sv */
/*
   Self-checking bench for the display RAM command decoder, host port driven here.
   Assumes ram_model on the RAM ports and a shortened init count.
*/
`timescale 1ns/1ps
module test_display_ram_command_decoder
   import lcd_cmd_pkg::*;
;
   // Strap values are arbitrary
   localparam logic [2:0] STRAP_MAKER = 3'h6;
   localparam logic [1:0] STRAP_SIZE  = 2'h1;

   logic              clk;
   logic              rst;
   logic              strobe;
   logic              dcs;
   logic              rnw;
   logic              chip_select_low;
   logic [7:0]        wdata;
   logic [2:0]        maker;
   logic [1:0]        size;
   logic              stall;
   logic              slow;
   logic [7:0]        o_rdata;
   logic              o_busy;
   ram_wr_s           ram_wr;
   logic              wr_valid;
   logic              wr_ready;
   logic              rd_en;
   ram_addr_s         rd_addr;
   logic [7:0]        ram_rdata;
   logic              o_panel_enable;
   logic [LINE_W-1:0] o_start_line;
   logic [LINE_W-1:0] o_start_row;
   logic [PAGE_W-1:0] o_page;
   logic [COL_W-1:0]  o_column;
   logic              o_read_hold;
   int                n_mismatch;
   int                check_count;

   display_ram_command_decoder #(.INIT_COUNT(8)) uut (
      .i_clk(clk), .i_sys_rst(rst), .i_chip_select_low(chip_select_low),
      .i_data_command_select(dcs), .i_read_not_write(rnw), .i_strobe(strobe),
      .i_wdata(wdata), .o_rdata(o_rdata), .o_busy(o_busy),
      .i_maker_identity_field(maker), .i_panel_size_field(size),
      .o_ram_wr(ram_wr), .o_ram_wr_valid(wr_valid), .i_ram_wr_ready(wr_ready),
      .o_ram_rd_en(rd_en), .o_ram_rd_addr(rd_addr), .i_ram_rdata(ram_rdata),
      .o_panel_enable(o_panel_enable), .o_start_line(o_start_line),
      .o_start_row(o_start_row), .o_page(o_page), .o_column(o_column),
      .o_read_hold(o_read_hold));

   ram_model ram (
      .i_clk(clk), .i_sys_rst(rst), .i_stall(stall), .i_slow(slow),
      .i_wr(ram_wr), .i_wr_valid(wr_valid), .o_wr_ready(wr_ready),
      .i_rd_en(rd_en), .i_rd_addr(rd_addr), .o_rdata(ram_rdata));

   always #4 clk = ~clk;

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Strobe stays high so back-to-back calls give one access per cycle
   task automatic acc(input logic dc, input logic r, input logic [7:0] d);
      strobe = 1'b1;
      dcs = dc;
      rnw = r;
      wdata = d;
      @(posedge clk);
      #1;
   endtask

   task automatic idle(input int n);
      strobe = 1'b0;
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic cmd(input logic [7:0] b);
      acc(1'b0, 1'b0, b);
      idle(1);
   endtask

   task automatic rd();
      acc(1'b1, 1'b1, 8'h00);
      idle(1);
   endtask

   task automatic wait_low(input logic which);
      int k;
      for (k = 0; k < 200 && (which ? o_busy : wr_valid) !== 1'b0; k++)
      begin
         @(posedge clk);
         #1;
      end
      if ((which ? o_busy : wr_valid) !== 1'b0)
      begin
         n_mismatch++;
         stop_test();
      end
   endtask

   task automatic t_reset();
      acc(1'b0, 1'b1, 8'h00);
      idle(1);
      chk(o_rdata, {3'b101, STRAP_MAKER, STRAP_SIZE});
      cmd(8'hb5);
      chk(o_page, 4'h0);
      wait_low(1'b1);
      acc(1'b0, 1'b1, 8'h00);
      idle(1);
      chk(o_rdata, {3'b000, STRAP_MAKER, STRAP_SIZE});
      maker = 3'h3;
      size = 2'h3;
      acc(1'b0, 1'b1, 8'h00);
      idle(1);
      chk(o_rdata, 8'h0f);
   endtask

   task automatic t_pointers();
      cmd(8'hbf);
      chk(o_page, 4'hf);
      cmd(8'h19);
      cmd(8'h0f);
      chk(o_column, 8'h9f);
      cmd(8'h03);
      chk(o_column, 8'h93);
      // Deselected chip must ignore a page command
      chip_select_low = 1'b1;
      cmd(8'hb1);
      chip_select_low = 1'b0;
      chk(o_page, 4'hf);
      chk({o_start_line, o_start_row, o_panel_enable}, 15'h0000);
   endtask

   task automatic t_write_fifo();
      int i;
      stall = 1'b1;
      cmd(8'hb3);
      cmd(8'h19);
      cmd(8'h0e);
      for (i = 0; i < 16; i++)
         acc(1'b1, 1'b0, 8'h10 + 8'(i));
      idle(1);
      chk(o_busy, 1'b1);
      chk(o_column, 8'h0e);
      chk(ram_wr, {4'h3, 8'h9e, 8'h10});
      acc(1'b1, 1'b0, 8'hff);
      acc(1'b0, 1'b0, 8'hb7);
      idle(1);
      chk({o_page, o_column}, 12'h30e);
      stall = 1'b0;
      slow = 1'b1;
      wait_low(1'b0);
      cmd(8'hb3);
      cmd(8'h19);
      cmd(8'h0e);
      rd();
      rd();
      chk(o_rdata, 8'h10);
      rd();
      chk(o_rdata, 8'h11);
      rd();
      chk(o_rdata, 8'h12);
      chk(o_column, 8'h02);
   endtask

   task automatic t_hold();
      cmd(8'h10);
      cmd(8'h05);
      cmd(8'he0);
      chk(o_read_hold, 1'b1);
      rd();
      rd();
      chk(o_column, 8'h05);
      // Enter again, then a write, so the cancel must undo a real advance
      cmd(8'he0);
      acc(1'b1, 1'b0, 8'h55);
      chk(o_column, 8'h06);
      acc(1'b0, 1'b0, 8'hee);
      idle(1);
      chk({o_read_hold, o_column}, 9'h005);
   endtask

   task automatic t_display();
      cmd(8'haf);
      acc(1'b0, 1'b1, 8'h00);
      idle(1);
      chk({o_panel_enable, o_rdata[6]}, 2'b11);
      cmd(8'hae);
      acc(1'b0, 1'b1, 8'h00);
      idle(1);
      chk({o_panel_enable, o_rdata[6]}, 2'b00);
      cmd(8'hb9);
      chk(o_page, 4'h9);
   endtask

   task automatic t_scroll();
      acc(1'b0, 1'b0, 8'h40);
      cmd(8'hff);
      chk(o_start_line, 7'h7f);
      cmd(8'h44);
      acc(1'b1, 1'b0, 8'h77);
      idle(1);
      cmd(8'h25);
      chk({o_start_row, o_start_line}, 14'h12ff);
      acc(1'b0, 1'b0, 8'h43);
      cmd(8'h00);
      chk(o_start_line, 7'h00);
      // Top bit of the second byte is ignored
      acc(1'b0, 1'b0, 8'h47);
      cmd(8'h8a);
      chk(o_start_row, 7'h0a);
   endtask

   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      strobe = 1'b0;
      dcs = 1'b0;
      rnw = 1'b0;
      chip_select_low = 1'b0;
      wdata = 8'h00;
      maker = STRAP_MAKER;
      size = STRAP_SIZE;
      stall = 1'b0;
      slow = 1'b0;
      n_mismatch = 0;
      check_count = 0;
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      t_reset();
      t_pointers();
      t_write_fifo();
      t_hold();
      t_display();
      t_scroll();
      stop_test();
   end
endmodule // test_display_ram_command_decoder
